// ==== exec_pkg.sv ====
// Constants and types shared by the execution unit and its divider
`default_nettype none
package exec_pkg;
  // Opcode patterns
  localparam logic [7:0] OP_CMP_IMM_A = 8'hb4;
  localparam logic [7:0] OP_CMP_DIR_A = 8'hb5;
  localparam logic [7:0] OP_CMP_IND = 8'b1011_011?;
  localparam logic [7:0] OP_CMP_REG = 8'b1011_1???;
  localparam logic [7:0] OP_ZERO_A = 8'he4;
  localparam logic [7:0] OP_ZERO_C = 8'hc3;
  localparam logic [7:0] OP_ZERO_BIT = 8'hc2;
  localparam logic [7:0] OP_INV_A = 8'hf4;
  localparam logic [7:0] OP_INV_C = 8'hb3;
  localparam logic [7:0] OP_INV_BIT = 8'hb2;
  localparam logic [7:0] OP_BCD = 8'hd4;
  localparam logic [7:0] OP_RED_A = 8'h14;
  localparam logic [7:0] OP_RED_DIR = 8'h15;
  localparam logic [7:0] OP_RED_IND = 8'b0001_011?;
  localparam logic [7:0] OP_RED_REG = 8'b0001_1???;
  localparam logic [7:0] OP_DIVIDE = 8'h84;
  localparam logic [7:0] OP_LOOP_DIR = 8'hd5;
  localparam logic [7:0] OP_LOOP_REG = 8'b1101_1???;
  // Instruction lengths and machine cycles
  localparam logic [15:0] LEN_1 = 16'h0001;
  localparam logic [15:0] LEN_2 = 16'h0002;
  localparam logic [15:0] LEN_3 = 16'h0003;
  localparam logic [2:0] CYC_1 = 3'h1;
  localparam logic [2:0] CYC_2 = 3'h2;
  localparam logic [2:0] CYC_4 = 3'h4;
  localparam logic [2:0] CNT_ONE = 3'h1;
  // Decimal adjust figures
  localparam logic [3:0] BCD_MAX = 4'h9;
  localparam logic [8:0] BCD_ADJ_LO = 9'h006;
  localparam logic [8:0] BCD_ADJ_HI = 9'h060;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  // Field positions
  localparam int REG_SEL_LSB = 0;
  localparam int BIT_IDX_LSB = 0;
  localparam int SIGN_BIT = 7;
  localparam int CARRY_BIT = 8;
  // Operand locations
  typedef enum logic [2:0] {
    LOC_NONE, LOC_ACC, LOC_REG, LOC_DIRECT, LOC_INDIRECT, LOC_BIT, LOC_CARRY
  } loc_t;
endpackage : exec_pkg
`default_nettype wire

// ==== div_unit.sv ====
// Two-bit-per-cycle restoring divider for the unsigned divide
`default_nettype none
module div_unit
  import exec_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Load
  input wire logic load,
  input wire logic [7:0] dividend,
  input wire logic [7:0] divisor,
  // Result of the step now being formed
  output logic [7:0] quotient,
  output logic [7:0] remainder
);

  logic [15:0] acc_q, acc_d;
  logic [7:0] dsr_q, dsr_d;
  logic [15:0] step2;

  // One restoring step on {remainder, shifting dividend}
  function automatic logic [15:0] div_step(input logic [15:0] s,
                                           input logic [7:0] d);
    logic [8:0] t;
    logic [8:0] diff;
    t = {s[15:8], s[7]};
    diff = t - {1'b0, d};
    if (t >= {1'b0, d}) begin
      div_step = {diff[7:0], s[6:0], 1'b1};
    end else begin
      div_step = {t[7:0], s[6:0], 1'b0};
    end
  endfunction

  always_comb begin
    step2 = div_step(div_step(acc_q, dsr_q), dsr_q);
    acc_d = step2;
    dsr_d = dsr_q;
    if (load) begin
      acc_d = div_step(div_step({BYTE_ZERO, dividend}, divisor), divisor);
      dsr_d = divisor;
    end
    quotient = step2[7:0];
    remainder = step2[15:8];
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      acc_q <= 16'h0000;
      dsr_q <= 8'h00;
    end else begin
      acc_q <= acc_d;
      dsr_q <= dsr_d;
    end
  end

endmodule : div_unit
`default_nettype wire

// ==== exec_unit.sv ====
// Execution unit for compare, clear, complement, adjust, decrement, divide
// Functional notes
// - Compare-branch: 3 bytes, 2 cycles, pc+3, branch if unequal, carry if less.
// - Carry from unsigned comparison; neither compared operand is written.
// - Branch target is advanced pc plus signed last-byte displacement.
// - Clear accumulator to zero, one byte, one cycle, flags kept.
// - Bit clear on carry (1 byte) or direct bit (2 bytes), one cycle.
// - Invert accumulator bits in one cycle, flags kept.
// - Invert carry or direct bit in one cycle, other flags kept.
// - Read-modify-write of a port takes its output latch, not pins, except bit clear, which leaves read_latch low.
// - Adjust adds six if low nibble above nine or half carry; carry-out sets carry.
// - Then adds six to high nibble if carry or nibble above nine.
// - Adjust never clears carry, keeps overflow, one byte one cycle.
// - Decrement acc, register, direct or indirect, wraps to ff, no flags.
// - Divide: quotient to acc, remainder to B, flags cleared, 4 cycles.
// - Zero divisor sets overflow, carry still cleared.
// - Loop decrement wraps, branches only when result nonzero, no flags.
// - Loop counter is a working register or a direct byte only.
// - Register loop form: 2 bytes, 2 cycles, displacement on advanced pc.
`default_nettype none
module exec_unit
  import exec_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Instruction issue
  input wire logic start,
  input wire logic [7:0] opcode,
  input wire logic [7:0] byte2,
  input wire logic [7:0] byte3,
  input wire logic [15:0] pc_in,
  output logic busy,
  // Operand fetch decode
  output loc_t opnd_loc,
  output logic [2:0] bank_reg_sel,
  output logic pointer_reg,
  output logic read_latch,
  input wire logic [7:0] opnd_data,
  // Architectural state in
  input wire logic [7:0] acc_in,
  input wire logic [7:0] b_in,
  input wire logic carry_in,
  input wire logic half_carry_flag,
  input wire logic signed_wrap_in,
  // Results
  output logic done,
  output logic [15:0] pc_out,
  output logic [7:0] acc_out,
  output logic [7:0] b_out,
  output logic carry_out,
  output logic signed_wrap_flag,
  output logic wr_en,
  output loc_t wr_loc,
  output logic [7:0] wr_data
);

  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DIV} state_t;

  state_t state_q, state_d;
  logic [2:0] cnt_q, cnt_d;
  logic done_q, done_d;
  logic [15:0] pc_q, pc_d;
  logic [7:0] acc_q, acc_d;
  logic [7:0] b_q, b_d;
  logic carry_q, carry_d;
  logic wrap_q, wrap_d;
  logic wr_en_q, wr_en_d;
  loc_t wr_loc_q, wr_loc_d;
  logic [7:0] wr_data_q, wr_data_d;
  logic [7:0] quot, rem;
  logic div_load;
  logic opcode_q_is_loop, loop_d;

  // Nibble above nine, used by both adjust steps
  function automatic logic over_nine(input logic [3:0] n);
    over_nine = n > BCD_MAX;
  endfunction

  // Advanced pc plus sign-extended displacement
  function automatic logic [15:0] rel_target(input logic [15:0] pc,
                                             input logic [7:0] rel);
    rel_target = pc + {{8{rel[SIGN_BIT]}}, rel};
  endfunction

  div_unit u_div (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .load(div_load),
    .dividend(acc_in),
    .divisor(b_in),
    .quotient(quot),
    .remainder(rem)
  );

  // ----------------------------------------------------------------
  // Operand decode
  // ----------------------------------------------------------------
  always_comb begin
    bank_reg_sel = opcode[REG_SEL_LSB +: 3];
    pointer_reg = opcode[REG_SEL_LSB];
    opnd_loc = LOC_NONE;
    read_latch = 1'b0;
    casez (opcode)
      OP_CMP_DIR_A: opnd_loc = LOC_DIRECT;
      OP_CMP_IND: opnd_loc = LOC_INDIRECT;
      OP_CMP_REG: opnd_loc = LOC_REG;
      OP_ZERO_BIT: opnd_loc = LOC_BIT;
      OP_INV_BIT: begin
        opnd_loc = LOC_BIT;
        read_latch = 1'b1;
      end
      OP_RED_DIR, OP_LOOP_DIR: begin
        opnd_loc = LOC_DIRECT;
        read_latch = 1'b1;
      end
      OP_RED_IND: begin
        opnd_loc = LOC_INDIRECT;
        read_latch = 1'b1;
      end
      OP_RED_REG, OP_LOOP_REG: begin
        opnd_loc = LOC_REG;
        read_latch = 1'b1;
      end
      default: opnd_loc = LOC_NONE;
    endcase
  end

  // ----------------------------------------------------------------
  // Execute and sequence
  // ----------------------------------------------------------------
  always_comb begin
    logic [2:0] cyc;
    logic [15:0] len;
    logic [7:0] lhs, rhs, dec_val, rel, bmask;
    logic take;
    logic [8:0] s1, s2;
    logic c1;
    cyc = CYC_1;
    len = LEN_1;
    lhs = acc_in;
    rhs = byte2;
    dec_val = opnd_data - BYTE_ONE;
    rel = byte3;
    bmask = BYTE_ONE << byte2[BIT_IDX_LSB +: 3];
    take = 1'b0;
    s1 = 9'h000;
    s2 = 9'h000;
    c1 = 1'b0;
    state_d = state_q;
    cnt_d = cnt_q;
    done_d = 1'b0;
    pc_d = pc_q;
    acc_d = acc_q;
    b_d = b_q;
    carry_d = carry_q;
    wrap_d = wrap_q;
    wr_en_d = 1'b0;
    wr_loc_d = wr_loc_q;
    wr_data_d = wr_data_q;
    div_load = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (start) begin
          acc_d = acc_in;
          b_d = b_in;
          carry_d = carry_in;
          wrap_d = signed_wrap_in;
          wr_loc_d = opnd_loc;
          wr_data_d = opnd_data;
          casez (opcode)
            OP_CMP_IMM_A, OP_CMP_DIR_A, OP_CMP_IND, OP_CMP_REG: begin
              len = LEN_3;
              cyc = CYC_2;
              if (opcode == OP_CMP_DIR_A) begin
                rhs = opnd_data;
              end else if (opcode != OP_CMP_IMM_A) begin
                lhs = opnd_data;
              end
              take = lhs != rhs;
              carry_d = lhs < rhs;
            end
            OP_ZERO_A: acc_d = BYTE_ZERO;
            OP_ZERO_C: carry_d = 1'b0;
            OP_ZERO_BIT: begin
              len = LEN_2;
              wr_en_d = 1'b1;
              wr_data_d = opnd_data & ~bmask;
            end
            OP_INV_A: acc_d = ~acc_in;
            OP_INV_C: carry_d = ~carry_in;
            OP_INV_BIT: begin
              len = LEN_2;
              wr_en_d = 1'b1;
              wr_data_d = opnd_data ^ bmask;
            end
            OP_BCD: begin
              s1 = {1'b0, acc_in};
              if (over_nine(acc_in[3:0]) || half_carry_flag) begin
                s1 = s1 + BCD_ADJ_LO;
              end
              c1 = carry_in | s1[CARRY_BIT];
              s2 = {1'b0, s1[7:0]};
              if (c1 || over_nine(s1[7:4])) begin
                s2 = s2 + BCD_ADJ_HI;
              end
              acc_d = s2[7:0];
              carry_d = c1 | s2[CARRY_BIT];
            end
            OP_RED_A: acc_d = acc_in - BYTE_ONE;
            OP_RED_DIR, OP_RED_IND, OP_RED_REG: begin
              if (opcode == OP_RED_DIR) begin
                len = LEN_2;
              end
              wr_en_d = 1'b1;
              wr_data_d = dec_val;
            end
            OP_DIVIDE: begin
              cyc = CYC_4;
              div_load = 1'b1;
              carry_d = 1'b0;
              wrap_d = b_in == BYTE_ZERO;
            end
            OP_LOOP_DIR, OP_LOOP_REG: begin
              cyc = CYC_2;
              len = (opcode == OP_LOOP_DIR) ? LEN_3 : LEN_2;
              rel = (opcode == OP_LOOP_DIR) ? byte3 : byte2;
              wr_en_d = 1'b1;
              wr_data_d = dec_val;
              take = dec_val != BYTE_ZERO;
            end
            default: wr_loc_d = LOC_NONE;
          endcase
          pc_d = pc_in + len;
          if (take) begin
            pc_d = rel_target(pc_in + len, rel);
          end
          if (cyc == CYC_1) begin
            done_d = 1'b1;
          end else begin
            cnt_d = cyc - CNT_ONE;
            state_d = (opcode == OP_DIVIDE) ? ST_DIV : ST_RUN;
            wr_en_d = 1'b0;
          end
        end
      end
      ST_RUN, ST_DIV: begin
        cnt_d = cnt_q - CNT_ONE;
        if (cnt_q == CNT_ONE) begin
          done_d = 1'b1;
          wr_en_d = (wr_loc_q != LOC_NONE) && (state_q == ST_RUN) &&
                    (opcode_q_is_loop);
          state_d = ST_IDLE;
          if (state_q == ST_DIV) begin
            acc_d = quot;
            b_d = rem;
          end
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // Loop writes its counter at the end; compare writes nothing
  always_comb begin
    loop_d = opcode_q_is_loop;
    if (state_q == ST_IDLE && start) begin
      loop_d = (opcode == OP_LOOP_DIR) || (opcode ==? OP_LOOP_REG);
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      cnt_q <= 3'h0;
      done_q <= 1'b0;
      pc_q <= 16'h0000;
      acc_q <= 8'h00;
      b_q <= 8'h00;
      carry_q <= 1'b0;
      wrap_q <= 1'b0;
      wr_en_q <= 1'b0;
      wr_loc_q <= LOC_NONE;
      wr_data_q <= 8'h00;
      opcode_q_is_loop <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      done_q <= done_d;
      pc_q <= pc_d;
      acc_q <= acc_d;
      b_q <= b_d;
      carry_q <= carry_d;
      wrap_q <= wrap_d;
      wr_en_q <= wr_en_d;
      wr_loc_q <= wr_loc_d;
      wr_data_q <= wr_data_d;
      opcode_q_is_loop <= loop_d;
    end
  end

  assign busy = state_q != ST_IDLE;
  assign done = done_q;
  assign pc_out = pc_q;
  assign acc_out = acc_q;
  assign b_out = b_q;
  assign carry_out = carry_q;
  assign signed_wrap_flag = wrap_q;
  assign wr_en = wr_en_q;
  assign wr_loc = wr_loc_q;
  assign wr_data = wr_data_q;

endmodule : exec_unit
`default_nettype wire

// ==== exec_unit_properties.sv ====
// Concurrent checks on the execution unit ports
`default_nettype none
module exec_unit_props
  import exec_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Issue
  input wire logic start,
  input wire logic busy,
  input wire logic [7:0] opcode,
  input wire logic [7:0] byte2,
  input wire logic [15:0] pc_in,
  input wire logic [7:0] acc_in,
  input wire logic [7:0] b_in,
  input wire logic carry_in,
  input wire logic signed_wrap_in,
  input wire logic [7:0] opnd_data,
  input wire logic read_latch,
  // Results
  input wire logic done,
  input wire logic [15:0] pc_out,
  input wire logic [7:0] acc_out,
  input wire logic carry_out,
  input wire logic signed_wrap_flag,
  input wire logic wr_en,
  input wire logic [7:0] wr_data
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sequence s_go(logic [7:0] op);
    start && !busy && opcode == op;
  endsequence
  property p_zero_acc;
    s_go(OP_ZERO_A) |=> done && acc_out == 8'h00 &&
      pc_out == $past(pc_in) + LEN_1;
  endproperty
  a_zero_acc: assert property (p_zero_acc)
    else $error("acc clear wrong");
  property p_cmp;
    s_go(OP_CMP_IMM_A) |=> busy ##1 done &&
      carry_out == ($past(acc_in, 2) < $past(byte2, 2));
  endproperty
  a_cmp: assert property (p_cmp)
    else $error("compare wrong");
  property p_div;
    s_go(OP_DIVIDE) |=> busy [*3] ##1 done && !carry_out;
  endproperty
  a_div: assert property (p_div)
    else $error("divide timing wrong");
  property p_div0;
    s_go(OP_DIVIDE) ##0 b_in == 8'h00 |-> ##4 signed_wrap_flag;
  endproperty
  a_div0: assert property (p_div0)
    else $error("zero divisor flag wrong");
  property p_inv;
    s_go(OP_INV_A) |=> acc_out == ~$past(acc_in) &&
      carry_out == $past(carry_in);
  endproperty
  a_inv: assert property (p_inv)
    else $error("acc invert wrong");
  property p_latch;
    s_go(OP_INV_BIT) |-> read_latch;
  endproperty
  a_latch: assert property (p_latch)
    else $error("latch select missing");
  property p_bcd;
    s_go(OP_BCD) |=> signed_wrap_flag == $past(signed_wrap_in) &&
      (carry_out || !$past(carry_in));
  endproperty
  a_bcd: assert property (p_bcd)
    else $error("adjust flags wrong");
  property p_red;
    s_go(OP_RED_A) |=> acc_out == $past(acc_in) - BYTE_ONE;
  endproperty
  a_red: assert property (p_red)
    else $error("decrement wrong");
  property p_loop;
    s_go(OP_LOOP_DIR) |=> ##1 done && wr_en &&
      wr_data == $past(opnd_data, 2) - BYTE_ONE;
  endproperty
  a_loop: assert property (p_loop)
    else $error("loop count wrong");
endmodule // exec_unit_props
`default_nettype wire

// ==== exec_unit_bench.sv ====
// Self-checking bench for the execution unit
`default_nettype none
module exec_unit_bench import exec_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Signals and instance
  // ----------------------------------------
  logic mclk, sys_rst, start, busy, read_latch, pointer_reg, done;
  logic [7:0] opcode, byte2, byte3, opnd_data, acc_in, b_in;
  logic carry_in, half_carry_flag, signed_wrap_in;
  logic [15:0] pc_in, pc_out;
  logic [2:0] bank_reg_sel;
  logic [7:0] acc_out, b_out, wr_data;
  logic carry_out, signed_wrap_flag, wr_en;
  loc_t opnd_loc, wr_loc;
  logic [8:0] exp;
  logic [7:0] av [4] = '{8'hbe, 8'hc9, 8'h12, 8'h99};
  int n_mismatch = 0, n_tests = 0, cycles = 0;
  exec_unit DUT (.mclk(mclk), .sys_rst(sys_rst), .start(start),
    .opcode(opcode), .byte2(byte2), .byte3(byte3), .pc_in(pc_in),
    .busy(busy), .opnd_loc(opnd_loc), .bank_reg_sel(bank_reg_sel),
    .pointer_reg(pointer_reg), .read_latch(read_latch),
    .opnd_data(opnd_data), .acc_in(acc_in), .b_in(b_in),
    .carry_in(carry_in), .half_carry_flag(half_carry_flag),
    .signed_wrap_in(signed_wrap_in), .done(done), .pc_out(pc_out),
    .acc_out(acc_out), .b_out(b_out), .carry_out(carry_out),
    .signed_wrap_flag(signed_wrap_flag), .wr_en(wr_en), .wr_loc(wr_loc),
    .wr_data(wr_data));
  initial begin
    mclk = 1'h0;
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 1000) begin
      n_mismatch++;
      summarize();
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic summarize();
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, e);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic run(input logic [7:0] op, b2, b3, d, input int cyc);
    int n;
    @(negedge mclk);
    opcode = op;
    byte2 = b2;
    byte3 = b3;
    opnd_data = d;
    start = 1'h1;
    @(negedge mclk);
    start = 1'h0;
    n = 1;
    while (done !== 1'h1 && n < 8) begin
      @(negedge mclk);
      n++;
    end
    chk(16'(n), 16'(cyc));
  endtask
  function automatic logic [8:0] bcd_exp(logic [7:0] a, logic ac, c);
    logic [8:0] r;
    logic cy;
    r = {1'h0, a};
    if (r[3:0] > 4'h9 || ac) r = r + 9'h006;
    cy = c | r[8];
    r = {1'h0, r[7:0]};
    if (r[7:4] > 4'h9 || cy) r = r + 9'h060;
    return {cy | r[8], r[7:0]};
  endfunction
  task automatic t_compare();
    acc_in = 8'h34;
    run(OP_CMP_IMM_A, 8'h56, 8'hf0, 8'h00, 2);
    chk(carry_out, 1'h1);
    chk(pc_out, 16'h00f3);
    chk(wr_en, 1'h0);
    run(OP_CMP_IMM_A, 8'h34, 8'hf0, 8'h00, 2);
    chk(carry_out, 1'h0);
    chk(pc_out, 16'h0103);
    run(OP_CMP_DIR_A, 8'h90, 8'h08, 8'h35, 2);
    chk(carry_out, 1'h1);
    chk(opnd_loc, LOC_DIRECT);
    run(8'hbf, 8'h60, 8'h10, 8'h56, 2);
    chk(bank_reg_sel, 3'h7);
    chk(pc_out, 16'h0113);
    run(8'hb7, 8'h10, 8'h04, 8'h80, 2);
    chk(pointer_reg, 1'h1);
    chk(carry_out, 1'h0);
  endtask
  task automatic t_bits();
    acc_in = 8'h5c;
    carry_in = 1'h1;
    run(OP_ZERO_A, 8'h00, 8'h00, 8'h00, 1);
    chk(acc_out, 8'h00);
    chk(carry_out, 1'h1);
    run(OP_INV_A, 8'h00, 8'h00, 8'h00, 1);
    chk(acc_out, 8'ha3);
    run(OP_ZERO_C, 8'h00, 8'h00, 8'h00, 1);
    chk(carry_out, 1'h0);
    chk(pc_out, 16'h0101);
    run(OP_ZERO_BIT, 8'h92, 8'h00, 8'h5d, 1);
    chk(wr_data, 8'h59);
    chk(pc_out, 16'h0102);
    run(OP_INV_C, 8'h00, 8'h00, 8'h00, 1);
    chk(carry_out, 1'h0);
    run(OP_INV_BIT, 8'h91, 8'h00, 8'h5d, 1);
    chk(read_latch, 1'h1);
    chk(wr_data, 8'h5f);
  endtask
  task automatic t_bcd();
    signed_wrap_in = 1'h1;
    for (int i = 0; i < 4; i++) begin
      acc_in = av[i];
      half_carry_flag = i[0];
      carry_in = i[1];
      exp = bcd_exp(av[i], i[0], i[1]);
      run(OP_BCD, 8'h00, 8'h00, 8'h00, 1);
      chk(acc_out, exp[7:0]);
      chk(carry_out, exp[8]);
      chk(signed_wrap_flag, 1'h1);
    end
  endtask
  task automatic t_dec();
    acc_in = 8'h00;
    run(OP_RED_A, 8'h00, 8'h00, 8'h00, 1);
    chk(acc_out, 8'hff);
    chk(carry_out, carry_in);
    run(8'h1b, 8'h00, 8'h00, 8'h00, 1);
    chk(wr_data, 8'hff);
    chk(bank_reg_sel, 3'h3);
    chk(read_latch, 1'h1);
    run(OP_RED_DIR, 8'h90, 8'h00, 8'h40, 1);
    chk(wr_data, 8'h3f);
    run(8'h16, 8'h00, 8'h00, 8'h7f, 1);
    chk(pointer_reg, 1'h0);
  endtask
  task automatic t_div();
    acc_in = 8'hfb;
    b_in = 8'h12;
    carry_in = 1'h1;
    run(OP_DIVIDE, 8'h00, 8'h00, 8'h00, 4);
    chk(acc_out, 8'h0d);
    chk(b_out, 8'h11);
    chk(signed_wrap_flag, 1'h0);
    b_in = 8'h00;
    run(OP_DIVIDE, 8'h00, 8'h00, 8'h00, 4);
    chk(signed_wrap_flag, 1'h1);
    chk(carry_out, 1'h0);
  endtask
  task automatic t_loop();
    run(8'hd9, 8'h10, 8'h00, 8'h01, 2);
    chk(wr_data, 8'h00);
    chk(wr_loc, LOC_REG);
    chk(pc_out, 16'h0102);
    run(8'hd9, 8'h10, 8'h00, 8'h00, 2);
    chk(wr_data, 8'hff);
    chk(pc_out, 16'h0112);
    run(OP_LOOP_DIR, 8'h50, 8'hfe, 8'h70, 2);
    chk(wr_data, 8'h6f);
    chk(pc_out, 16'h0101);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    sys_rst = 1'h1;
    start = 1'h0;
    {opcode, byte2, byte3, opnd_data, acc_in, b_in} = 48'h0;
    {carry_in, half_carry_flag, signed_wrap_in} = 3'h0;
    pc_in = 16'h0100;
    repeat (10) @(negedge mclk);
    chk(done, 1'h0);
    chk(acc_out, 8'h00);
    sys_rst = 1'h0;
    t_compare();
    t_bits();
    t_bcd();
    t_dec();
    t_div();
    t_loop();
    summarize();
  end
endmodule // exec_unit_bench
bind exec_unit exec_unit_props chk_u (.mclk(mclk), .sys_rst(sys_rst),
  .start(start), .busy(busy), .opcode(opcode), .byte2(byte2),
  .pc_in(pc_in), .acc_in(acc_in), .b_in(b_in), .carry_in(carry_in),
  .signed_wrap_in(signed_wrap_in), .opnd_data(opnd_data),
  .read_latch(read_latch), .done(done), .pc_out(pc_out),
  .acc_out(acc_out), .carry_out(carry_out),
  .signed_wrap_flag(signed_wrap_flag), .wr_en(wr_en),
  .wr_data(wr_data));
`default_nettype wire
